/* pgs_pkg.sv */
//==========================================================
// shared constants and carriers of the gear scaler
package pgs_pkg;
	// gear setting limits and defaults
	localparam logic [31:0] GEAR_MAX = 32'h4000_0000; // largest accepted value
	localparam logic [31:0] GEAR_MIN = 32'h0000_0001; // smallest accepted value
	localparam logic [30:0] NUM_DEF = 31'h0000_0004; // numerator default
	localparam logic [30:0] DEN_DEF = 31'h0000_0001; // denominator default

	//==========================================================
	// encoder resolution per revolution and count factor
	localparam logic [20:0] RES_13 = 21'h00_0800; // 13-bit encoder
	localparam logic [20:0] RES_16 = 21'h00_4000; // 16-bit encoder
	localparam logic [20:0] RES_17 = 21'h00_8000; // 17-bit encoder
	localparam logic [20:0] RES_20 = 21'h04_0000; // 20-bit encoder
	localparam logic [20:0] CNT_FACTOR = 21'h00_0004; // four counts per pulse

	//==========================================================
	// types
	typedef enum logic [1:0] {ENC_13, ENC_16, ENC_17, ENC_20} pgs_enc_t; // encoder kind

	typedef struct packed {
		logic [31:0] num; // written numerator
		logic [31:0] den; // written denominator
	} pgs_gear_set_t;

	typedef struct packed {
		logic [30:0] num; // active numerator
		logic [30:0] den; // active denominator
	} pgs_gear_t;
endpackage : pgs_pkg

/* pgs_divider.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// restoring divider, one quotient bit per clock
module pgs_divider #(
	parameter int W = 32
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic [W-1:0] dividend,
	input wire logic [W-1:0] divisor,
	output logic busy,
	output logic done,
	output logic [W-1:0] quotient,
	output logic [W-1:0] remainder
);
	localparam int CW = $clog2(W + 1);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);
	localparam logic [CW-1:0] CNT_FULL = CW'(W);

	logic [W-1:0] q_ff, nxt_q; // shifting dividend, becomes quotient
	logic [W:0] r_ff, nxt_r; // partial remainder
	logic [W-1:0] d_ff, nxt_d; // held divisor
	logic [CW-1:0] cnt_ff, nxt_cnt; // bits left
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic [W:0] shifted; // remainder with next dividend bit
	logic fits; // trial subtraction succeeds

	//==========================================================
	// next-state computation
	always_comb begin
		nxt_q = q_ff;
		nxt_r = r_ff;
		nxt_d = d_ff;
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		shifted = {r_ff[W-1:0], q_ff[W-1]};
		fits = (shifted >= {1'b0, d_ff});
		if (start && !busy_ff) begin
			// load operands
			nxt_q = dividend;
			nxt_r = '0;
			nxt_d = divisor;
			nxt_cnt = CNT_FULL;
			nxt_busy = 1'b1;
		end else if (busy_ff) begin
			// one restoring step
			nxt_r = fits ? (shifted - {1'b0, d_ff}) : shifted;
			nxt_q = {q_ff[W-2:0], fits};
			nxt_cnt = cnt_ff - CNT_ONE;
			if (cnt_ff == CNT_ONE) begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end
		end
	end

	//==========================================================
	// registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			q_ff <= '0;
			r_ff <= '0;
			d_ff <= '0;
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			q_ff <= nxt_q;
			r_ff <= nxt_r;
			d_ff <= nxt_d;
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	assign busy = busy_ff;
	assign done = done_ff;
	assign quotient = q_ff;
	assign remainder = r_ff[W-1:0];

	//==========================================================
	// checks
	property p_div_latency;
		@(posedge mclk) disable iff (rst)
		(start && !busy_ff) |=> busy_ff [*2] ##[1:40] done_ff;
	endproperty
	a_div_latency: assert property (p_div_latency)
		else $error("divider did not finish in time");

	property p_div_exact;
		@(posedge mclk) disable iff (rst)
		done_ff |-> (r_ff < {1'b0, d_ff});
	endproperty
	a_div_exact: assert property (p_div_exact)
		else $error("divider remainder not below divisor");
endmodule : pgs_divider
`default_nettype wire

/* pgs_gear_scaler.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - one reference pulse is one reference unit
// - numerator 1..2^30, default 4, adopted at restart
// - denominator 1..2^30, default 1, adopted at restart
// - encoder resolution by type, times four
module pgs_gear_scaler #(
	parameter int PW = 48, // feedback position width
	parameter int QW = 16 // pending reference counter width
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ref_pulse, // reference pulse pin, async
	input wire logic ref_dir, // reference direction pin, 1 = reverse
	input wire pgs_pkg::pgs_gear_set_t gear_set, // written gear settings
	input wire logic gear_set_valid, // settings present, else defaults
	input wire pgs_pkg::pgs_enc_t enc_type, // encoder kind
	output pgs_pkg::pgs_gear_t gear_active, // ratio in use
	output logic [20:0] counts_per_rev, // feedback counts per revolution
	output logic signed [PW-1:0] fb_pos, // accumulated encoder counts
	output logic signed [32:0] fb_step, // counts added by last conversion
	output logic fb_valid, // one-cycle pulse per conversion
	output logic ready // settings adopted, converting
);
	localparam logic signed [QW-1:0] Q_ONE = QW'(1);

	typedef enum {ST_LOAD, ST_IDLE, ST_DIV} pgs_state_t;

	//==========================================================
	// pin synchronisers
	logic ref_meta_ff, ref_sync_ff, ref_prev_ff; // pulse pin chain
	logic dir_meta_ff, dir_sync_ff; // direction pin chain
	logic ref_edge; // new reference unit

	always_ff @(posedge mclk) begin
		if (rst) begin
			ref_meta_ff <= 1'b0;
			ref_sync_ff <= 1'b0;
			ref_prev_ff <= 1'b0;
			dir_meta_ff <= 1'b0;
			dir_sync_ff <= 1'b0;
		end else begin
			ref_meta_ff <= ref_pulse;
			ref_sync_ff <= ref_meta_ff;
			ref_prev_ff <= ref_sync_ff;
			dir_meta_ff <= ref_dir;
			dir_sync_ff <= dir_meta_ff;
		end
	end

	// rising edge of the clean pulse is one unit
	assign ref_edge = ref_sync_ff && !ref_prev_ff;

	//==========================================================
	// clamp a written setting into its legal range
	function automatic logic [30:0] clamp_gear(input logic [31:0] v);
		logic [31:0] c;
		c = v;
		if (v < pgs_pkg::GEAR_MIN) begin
			c = pgs_pkg::GEAR_MIN;
		end else if (v > pgs_pkg::GEAR_MAX) begin
			c = pgs_pkg::GEAR_MAX;
		end
		return c[30:0];
	endfunction : clamp_gear

	//==========================================================
	// state
	pgs_state_t state_ff, nxt_state; // converter sequence
	pgs_pkg::pgs_gear_t gear_ff, nxt_gear; // active ratio
	logic [20:0] cpr_ff, nxt_cpr; // counts per revolution
	logic signed [QW-1:0] pend_ff, nxt_pend; // units waiting
	logic [30:0] rem_ff, nxt_rem; // carried fraction numerator
	logic rev_ff, nxt_rev; // direction of current conversion
	logic signed [PW-1:0] pos_ff, nxt_pos;
	logic signed [32:0] step_ff, nxt_step;
	logic valid_ff, nxt_valid;
	logic take; // one unit leaves the queue
	logic div_start, div_busy, div_done;
	logic [31:0] div_a, div_b, div_q, div_r;

	//==========================================================
	// next values
	always_comb begin
		nxt_state = state_ff;
		nxt_gear = gear_ff;
		nxt_cpr = cpr_ff;
		nxt_rem = rem_ff;
		nxt_rev = rev_ff;
		nxt_pos = pos_ff;
		nxt_step = step_ff;
		nxt_valid = 1'b0;
		take = 1'b0;
		div_start = 1'b0;
		div_a = '0;
		div_b = {1'b0, gear_ff.den};
		unique case (state_ff)
			ST_LOAD: begin
				// settings are adopted only here, right after restart
				if (gear_set_valid) begin
					nxt_gear.num = clamp_gear(gear_set.num);
					nxt_gear.den = clamp_gear(gear_set.den);
				end else begin
					nxt_gear.num = pgs_pkg::NUM_DEF;
					nxt_gear.den = pgs_pkg::DEN_DEF;
				end
				// resolution times four per encoder kind
				unique case (enc_type)
					pgs_pkg::ENC_13: nxt_cpr = pgs_pkg::RES_13 * pgs_pkg::CNT_FACTOR;
					pgs_pkg::ENC_16: nxt_cpr = pgs_pkg::RES_16 * pgs_pkg::CNT_FACTOR;
					pgs_pkg::ENC_17: nxt_cpr = pgs_pkg::RES_17 * pgs_pkg::CNT_FACTOR;
					pgs_pkg::ENC_20: nxt_cpr = pgs_pkg::RES_20 * pgs_pkg::CNT_FACTOR;
				endcase
				nxt_rem = '0;
				nxt_state = ST_IDLE;
			end
			ST_IDLE: begin
				// start one unit; the ratio is num/den, the host keeps it sane
				if (pend_ff != '0) begin
					take = 1'b1;
					div_start = 1'b1;
					nxt_rev = pend_ff[QW-1];
					// reverse works on the mirrored fraction
					if (pend_ff[QW-1]) begin
						div_a = {1'b0, gear_ff.den - 31'h1 - rem_ff} + {1'b0, gear_ff.num};
					end else begin
						div_a = {1'b0, rem_ff} + {1'b0, gear_ff.num};
					end
					nxt_state = ST_DIV;
				end
			end
			ST_DIV: begin
				// whole counts go out, the fraction stays for later
				if (div_done) begin
					if (rev_ff) begin
						nxt_rem = gear_ff.den - 31'h1 - div_r[30:0];
						nxt_step = -$signed({1'b0, div_q});
					end else begin
						nxt_rem = div_r[30:0];
						nxt_step = $signed({1'b0, div_q});
					end
					nxt_pos = pos_ff + PW'(nxt_step);
					nxt_valid = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
		endcase
	end

	// queue of units: arrival and departure of the same direction in one cycle cancel
	always_comb begin
		nxt_pend = pend_ff;
		if (ref_edge) begin
			nxt_pend = dir_sync_ff ? (nxt_pend - Q_ONE) : (nxt_pend + Q_ONE);
		end
		if (take) begin
			nxt_pend = pend_ff[QW-1] ? (nxt_pend + Q_ONE) : (nxt_pend - Q_ONE);
		end
	end

	//==========================================================
	// registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_ff <= ST_LOAD;
			gear_ff.num <= pgs_pkg::NUM_DEF;
			gear_ff.den <= pgs_pkg::DEN_DEF;
			cpr_ff <= '0;
			pend_ff <= '0;
			rem_ff <= '0;
			rev_ff <= 1'b0;
			pos_ff <= '0;
			step_ff <= '0;
			valid_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			gear_ff <= nxt_gear;
			cpr_ff <= nxt_cpr;
			pend_ff <= nxt_pend;
			rem_ff <= nxt_rem;
			rev_ff <= nxt_rev;
			pos_ff <= nxt_pos;
			step_ff <= nxt_step;
			valid_ff <= nxt_valid;
		end
	end

	//==========================================================
	// divider
	pgs_divider #(
		.W(32)
	) u_div (
		.mclk(mclk),
		.rst(rst),
		.start(div_start),
		.dividend(div_a),
		.divisor(div_b),
		.busy(div_busy),
		.done(div_done),
		.quotient(div_q),
		.remainder(div_r)
	);

	assign gear_active = gear_ff;
	assign counts_per_rev = cpr_ff;
	assign fb_pos = pos_ff;
	assign fb_step = step_ff;
	assign fb_valid = valid_ff;
	assign ready = (state_ff != ST_LOAD);

	//==========================================================
	// checks
	property p_ref_unit;
		@(posedge mclk) disable iff (rst)
		(ref_edge && !dir_sync_ff && !take) |=> (pend_ff == $past(pend_ff) + Q_ONE);
	endproperty
	a_ref_unit: assert property (p_ref_unit)
		else $error("reference edge not counted as one unit");

	property p_num_range;
		@(posedge mclk) disable iff (rst)
		ready |-> (gear_ff.num != '0) && ({1'b0, gear_ff.num} <= pgs_pkg::GEAR_MAX);
	endproperty
	a_num_range: assert property (p_num_range)
		else $error("numerator out of range");

	property p_den_hold;
		@(posedge mclk) disable iff (rst)
		(ready && (gear_ff.den != '0)) |=> $stable(gear_ff.den) && $stable(gear_ff.num);
	endproperty
	a_den_hold: assert property (p_den_hold)
		else $error("gear ratio changed without restart");

	property p_cpr;
		@(posedge mclk) disable iff (rst)
		(state_ff == ST_LOAD && enc_type == pgs_pkg::ENC_20) |=> (cpr_ff == 21'h10_0000);
	endproperty
	a_cpr: assert property (p_cpr)
		else $error("wrong counts per revolution");

	property p_rem_below;
		@(posedge mclk) disable iff (rst)
		ready |-> (rem_ff < gear_ff.den);
	endproperty
	a_rem_below: assert property (p_rem_below)
		else $error("carried remainder not below denominator");

	property p_step_pos;
		@(posedge mclk) disable iff (rst)
		valid_ff |-> (pos_ff == $past(pos_ff) + PW'(step_ff));
	endproperty
	a_step_pos: assert property (p_step_pos)
		else $error("position not advanced by step");

	// the divider is only ever busy while a conversion is in flight
	property p_div_idle;
		@(posedge mclk) disable iff (rst)
		(state_ff == ST_IDLE) |-> !div_busy;
	endproperty
	a_div_idle: assert property (p_div_idle)
		else $error("divider busy while converter idle");
endmodule : pgs_gear_scaler
`default_nettype wire

/* pgs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// host controller model: picks the gear ratio, issues reference pulses
module pgs_host_model (
	input wire logic mclk,
	output logic ref_pulse,
	output logic ref_dir
);
	// idle: pulse low, direction forward
	initial begin
		ref_pulse = 1'b0;
		ref_dir = 1'b0;
	end

	// ratio kept within 0.01..100 and reduced to lowest terms
	task automatic pick_ratio(output longint n, output longint d);
		longint a;
		longint b;
		longint t;
		d = $urandom_range(1, 5000);
		n = $urandom_range(32'((d + 99) / 100), 32'(d * 100));
		a = n;
		b = d;
		while (b != 0) begin
			t = a % b;
			a = b;
			b = t;
		end
		n = n / a;
		d = d / a;
	endtask : pick_ratio

	// one unit: direction settles first, then one pulse, each level >= 2 cycles
	task automatic send_unit(input logic dir, input int hi, input int lo);
		ref_dir = dir;
		repeat (2) @(negedge mclk);
		ref_pulse = 1'b1;
		repeat (hi) @(negedge mclk);
		ref_pulse = 1'b0;
		repeat (lo) @(negedge mclk);
	endtask : send_unit
endmodule : pgs_host_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// self-checking bench of the gear scaler
module testbench;
	logic mclk; // 200 MHz clock
	logic rst; // sync reset
	logic ref_pulse; // from host model
	logic ref_dir; // from host model
	pgs_pkg::pgs_gear_set_t gear_set; // written settings
	logic gear_set_valid; // settings present
	pgs_pkg::pgs_enc_t enc_type; // encoder kind
	pgs_pkg::pgs_gear_t gear_active; // ratio in use
	logic [20:0] counts_per_rev; // counts per revolution
	logic signed [47:0] fb_pos; // accumulated counts
	logic signed [32:0] fb_step; // last increment
	logic fb_valid; // conversion pulse
	logic ready; // settings adopted
	int num_errors; // mismatches
	int checks; // comparisons
	longint num; // expected numerator
	longint den; // expected denominator
	longint net; // net reference units
	longint want; // expected position

	// clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	pgs_gear_scaler i_dut (.mclk(mclk), .rst(rst), .ref_pulse(ref_pulse), .ref_dir(ref_dir),
		.gear_set(gear_set), .gear_set_valid(gear_set_valid), .enc_type(enc_type),
		.gear_active(gear_active), .counts_per_rev(counts_per_rev), .fb_pos(fb_pos),
		.fb_step(fb_step), .fb_valid(fb_valid), .ready(ready));
	pgs_host_model i_host (.mclk(mclk), .ref_pulse(ref_pulse), .ref_dir(ref_dir));

	//==========================================================
	// reporting
	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : chk

	//==========================================================
	// expectations
	function automatic longint fdiv(input longint a, input longint b);
		return (a < 0 && a % b != 0) ? a / b - 1 : a / b;
	endfunction : fdiv

	// written setting as the device must adopt it, held to 1..2^30
	function automatic longint clampg(input longint v);
		return (v < 1) ? 64'sd1 : ((v > 64'sd1073741824) ? 64'sd1073741824 : v);
	endfunction : clampg

	function automatic logic [20:0] cpr(input pgs_pkg::pgs_enc_t e);
		case (e)
			pgs_pkg::ENC_13: return pgs_pkg::RES_13 * pgs_pkg::CNT_FACTOR;
			pgs_pkg::ENC_16: return pgs_pkg::RES_16 * pgs_pkg::CNT_FACTOR;
			pgs_pkg::ENC_17: return pgs_pkg::RES_17 * pgs_pkg::CNT_FACTOR;
			default: return pgs_pkg::RES_20 * pgs_pkg::CNT_FACTOR;
		endcase
	endfunction : cpr

	//==========================================================
	// restart with given settings; later writes must be ignored
	task automatic restart(input logic v, input longint n, input longint d,
		input pgs_pkg::pgs_enc_t e);
		int i;
		rst = 1'b1;
		gear_set_valid = v;
		gear_set.num = 32'(n);
		gear_set.den = 32'(d);
		enc_type = e;
		repeat (10) @(negedge mclk);
		chk(ready === 1'b0 && fb_valid === 1'b0 && fb_pos === 48'sh0, "reset state");
		chk(gear_active === {pgs_pkg::NUM_DEF, pgs_pkg::DEN_DEF}, "reset ratio");
		rst = 1'b0;
		for (i = 0; i < 10 && ready !== 1'b1; i++) @(negedge mclk);
		num = v ? clampg(n) : 64'sd4;
		den = v ? clampg(d) : 64'sd1;
		net = 0;
		want = 0;
		for (i = 0; i < 2; i++) begin
			chk(ready === 1'b1 && gear_active === {31'(num), 31'(den)}, "ratio");
			chk(counts_per_rev === cpr(e), "resolution");
			gear_set = ~gear_set;
			enc_type = pgs_pkg::pgs_enc_t'(~e);
			repeat (5) @(negedge mclk);
		end
	endtask : restart

	// wait one conversion and compare against the exact scaled total
	task automatic wait_conv();
		int i;
		longint w;
		for (i = 0; i < 100 && fb_valid !== 1'b1; i++) @(negedge mclk);
		if (fb_valid !== 1'b1) begin
			chk(1'b0, "no conversion");
			finish_test();
		end
		w = fdiv(net * num, den);
		chk(fb_pos === 48'(w), "position");
		chk(fb_step === 33'(w - want), "step");
		want = w;
		@(negedge mclk);
		chk(fb_valid === 1'b0, "valid pulse too long");
	endtask : wait_conv

	task automatic step(input logic dir);
		i_host.send_unit(dir, $urandom_range(2, 6), $urandom_range(2, 6));
		net = dir ? net - 1 : net + 1;
		wait_conv();
	endtask : step

	//==========================================================
	// main sequence
	initial begin
		int e;
		int r;
		int k;
		longint n;
		longint d;
		rst = 1'b1;
		gear_set = '0;
		gear_set_valid = 1'b0;
		enc_type = pgs_pkg::ENC_13;
		num_errors = 0;
		checks = 0;
		void'($urandom(32'h3ba2));
		@(negedge mclk);
		// defaults on every encoder kind
		for (e = 0; e < 4; e++) begin
			restart(1'b0, 0, 0, pgs_pkg::pgs_enc_t'(e));
			step(1'b0);
			step(1'b1);
		end
		// largest numerator
		restart(1'b1, 64'sd1073741824, 64'sd16777215, pgs_pkg::ENC_20);
		step(1'b0);
		step(1'b1);
		step(1'b1);
		// out-of-range settings are clamped: numerator down to 2^30, denominator up to 1
		restart(1'b1, 64'shffff_ffff, 64'sd0, pgs_pkg::ENC_16);
		step(1'b0);
		step(1'b1);
		// random ratios, directions and pulse widths, then a fast burst
		for (r = 0; r < 5; r++) begin
			i_host.pick_ratio(n, d);
			restart(1'b1, n, d, pgs_pkg::pgs_enc_t'($urandom_range(0, 3)));
			for (k = 0; k < 12; k++) begin
				step(1'($urandom_range(0, 1)));
			end
			for (k = 0; k < 4; k++) begin
				i_host.send_unit(1'b0, 2, 2);
			end
			for (k = 0; k < 4; k++) begin
				net++;
				wait_conv();
			end
		end
		finish_test();
	end
endmodule : testbench
`default_nettype wire
